// ==== rtl/cgacs_divider.sv ====
/*
 Programmable modulo divider of a tick stream: one output tick per
 modulus input ticks. A modulus of zero behaves as one.
 Assumes input ticks are single-cycle pulses on clk.
*/
`include "cgacs_consts.svh"

module cgacs_divider
    import cgacs_pkg::*;
#(
    parameter int W = 12
) (
    input wire logic clk,
    input wire logic rst_n_sync,
    input wire logic tick_in,
    input wire logic [W-1:0] modulus,
    output logic tick_out
);

    typedef struct packed {
        logic [W-1:0] count;
        logic out;
    } cgacs_div_state_t;

    cgacs_div_state_t st_reg;
    cgacs_div_state_t st_next;
    logic [W:0] count_inc;

    always_comb begin
        st_next = st_reg;
        count_inc = {1'b0, st_reg.count} + {{W{1'b0}}, 1'b1};
        st_next.out = 1'b0;
        if (tick_in) begin
            if (count_inc >= {1'b0, modulus}) begin
                st_next.count = '0;
                st_next.out = 1'b1;
            end else begin
                st_next.count = count_inc[W-1:0];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign tick_out = st_reg.out;

endmodule // cgacs_divider

// ==== rtl/cgacs_edge_sync.sv ====
/*
 Two-flop synchroniser with rising edge pulse for a pin-level clock.
 Assumes the pin toggles slower than a third of the system clock.
*/
`include "cgacs_consts.svh"

module cgacs_edge_sync
    import cgacs_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n_sync,
    input wire logic pin,
    output logic level,
    output logic rise
);

    cgacs_sync_state_t st_reg;
    cgacs_sync_state_t st_next;

    always_comb begin
        st_next = st_reg;
        st_next.s1 = pin;
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
        // Edge taken between second and third flop, never from the first
        st_next.rise = st_reg.s2 & ~st_reg.s3;
    end

    always_ff @(posedge clk or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign level = st_reg.s3;
    assign rise = st_reg.rise;

endmodule // cgacs_edge_sync

// ==== rtl/cgacs_top.sv ====
/*
 Digital side of the clock generator with the converter clock register:
 oscillator enable, crystal and reference clocks, base and bus clocks,
 feedback divider, phase and lock detectors, converter clock prescaler,
 result justification, Wishbone classic register slave and lock interrupt.
 Assumes crystal and VCO clocks arrive as pins well below clk/3, and the
 converter result and oscillator request come from logic on clk.
*/
`include "cgacs_consts.svh"

// Operation
// - The converter clock tick is the selected source divided by 1, 2, 4, 8, or 16 when the top prescaler bit is set.
// - The prescaler is fed by the bus clock when the source bit is 1 and by the crystal clock when 0, crystal after reset.
// - Results are formatted as 8-bit truncation, right, left, or left signed for justification 00, 01, 10, 11.
// - Reset leaves the justification field at right justified.
// - The base clock is the crystal clock halved or the VCO clock halved as software selects.
// - The bus clock runs at half the base clock.
// - Base and crystal clocks are both driven out to the system integration unit.
// - The oscillator is enabled while the request or the run-in-stop bit is set.
// - The crystal clock is output at crystal rate and buffered once more into the reference clock.
// - The VCO clock passes a modulo-N divider giving the feedback clock.
// - A phase detector compares feedback and final reference and emits up or down correction pulses.
// - A lock detector compares feedback and reference frequencies to choose filter mode and lock state.
// - In automatic mode the detector drives the read-only acquisition and lock indicators.
// - Each lock toggle raises the interrupt when enabled, and manual mode clears lock and blocks it.
module cgacs_top
    import cgacs_pkg::*;
#(
    parameter int MULT_W = `CGACS_MULT_W
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic irq_o,
    input wire logic crystal_pin,
    input wire logic vco_pin,
    input wire logic oscillator_enable_request,
    input wire logic [9:0] conv_result_raw,
    input wire logic conv_result_valid,
    output logic oscillator_enable,
    output logic crystal_clock,
    output logic pll_reference_clock,
    output logic base_clock,
    output logic base_source_vco,
    output logic bus_clock,
    output logic vco_feedback_clock,
    output logic final_reference_clock,
    output logic pump_up,
    output logic pump_down,
    output logic tracking_mode,
    output logic pll_locked,
    output logic converter_clock_tick,
    output logic [7:0] result_high,
    output logic [7:0] result_low,
    output logic result_valid
);

    logic [1:0] rst_sync_reg;
    logic rst_n_sync;
    cgacs_state_t st_reg;
    cgacs_state_t st_next;
    logic xtal_level;
    logic xtal_rise;
    logic vco_level;
    logic vco_rise;
    logic fb_tick;
    logic presc_tick_in;
    logic [4:0] presc_modulus;
    logic conv_tick;
    logic [2:0] presc_sel;
    logic conv_src;
    logic [1:0] just_sel;
    logic base_sel_req;
    logic auto_bw;
    logic acq_manual;
    logic run_in_stop;

    // Byte-lane merge of a write into a stored word
    function automatic logic [31:0] cgacs_merge(input logic [31:0] old,
                                                input logic [31:0] data,
                                                input logic [3:0] sel);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                res[i*8 +: 8] = data[i*8 +: 8];
            end
        end
        return res;
    endfunction

    function automatic logic [4:0] cgacs_presc_mod(input logic [2:0] sel);
        logic [4:0] m;
        m = 5'h10;
        if (!sel[2]) begin
            m = 5'(5'h01 << sel[1:0]);
        end
        return m;
    endfunction

    // Returns {high byte, low byte} of a formatted result
    function automatic logic [15:0] cgacs_justify(input logic [1:0] mode,
                                                  input logic [9:0] raw);
        logic [15:0] r;
        r = 16'h0000;
        case (mode)
            `CGACS_JUST_TRUNC: r = {8'h00, raw[9:2]};
            `CGACS_JUST_RIGHT: r = {6'h00, raw};
            `CGACS_JUST_LEFT: r = {raw, 6'h00};
            `CGACS_JUST_SIGNED: r = {~raw[9], raw[8:0], 6'h00};
            default: r = 16'h0000;
        endcase
        return r;
    endfunction

    function automatic logic [7:0] cgacs_absdiff(input logic [7:0] a,
                                                 input logic [7:0] b);
        logic [7:0] d;
        d = (a >= b) ? 8'(a - b) : 8'(b - a);
        return d;
    endfunction

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n_sync = rst_sync_reg[1];

    cgacs_edge_sync u_xtal_sync (
        .clk(clk),
        .rst_n_sync(rst_n_sync),
        .pin(crystal_pin),
        .level(xtal_level),
        .rise(xtal_rise)
    );

    cgacs_edge_sync u_vco_sync (
        .clk(clk),
        .rst_n_sync(rst_n_sync),
        .pin(vco_pin),
        .level(vco_level),
        .rise(vco_rise)
    );

    cgacs_divider #(.W(MULT_W)) u_fb_div (
        .clk(clk),
        .rst_n_sync(rst_n_sync),
        .tick_in(vco_rise),
        .modulus(st_reg.mult),
        .tick_out(fb_tick)
    );

    cgacs_divider #(.W(5)) u_presc (
        .clk(clk),
        .rst_n_sync(rst_n_sync),
        .tick_in(presc_tick_in),
        .modulus(presc_modulus),
        .tick_out(conv_tick)
    );

    assign presc_sel = st_reg.conv_ctl[`CGACS_CONV_PRESC_POS +: 3];
    assign conv_src = st_reg.conv_ctl[`CGACS_CONV_SRC_POS];
    assign just_sel = st_reg.conv_ctl[`CGACS_CONV_JUST_POS +: 2];
    assign base_sel_req = st_reg.clk_ctl[`CGACS_CTL_BASE_SEL_POS];
    assign auto_bw = st_reg.clk_ctl[`CGACS_CTL_AUTO_POS];
    assign acq_manual = st_reg.clk_ctl[`CGACS_CTL_ACQ_POS];
    assign run_in_stop = st_reg.clk_ctl[`CGACS_CTL_RIS_POS];
    assign presc_tick_in = conv_src ? st_reg.bus_rise : xtal_rise;
    assign presc_modulus = cgacs_presc_mod(presc_sel);

    always_comb begin
        logic req;
        logic wr;
        logic src_edge;
        logic lock_new;
        logic lock_evt;
        logic [7:0] diff;
        logic [31:0] rd;
        logic [15:0] fmt;
        req = 1'b0;
        wr = 1'b0;
        src_edge = 1'b0;
        lock_new = 1'b0;
        lock_evt = 1'b0;
        diff = 8'h00;
        rd = 32'h0000_0000;
        fmt = 16'h0000;
        st_next = st_reg;

        // Bus slave: one wait state, writes land with ack
        req = wb_cyc_i & wb_stb_i & ~st_reg.ack;
        wr = wb_cyc_i & wb_stb_i & wb_we_i & st_reg.ack;
        st_next.ack = req;
        case (wb_adr_i)
            `CGACS_OFS_CONV_CTL: rd = {24'h00_0000, st_reg.conv_ctl};
            `CGACS_OFS_CLK_CTL: rd = {28'h000_0000, st_reg.clk_ctl};
            `CGACS_OFS_MULT: rd = 32'(st_reg.mult);
            `CGACS_OFS_STATUS: rd = {28'h000_0000, st_reg.osc_en, st_reg.base_active,
                                     st_reg.acquisition_indicator, st_reg.lock};
            `CGACS_OFS_IRQ_STAT: rd = {31'h0000_0000, st_reg.irq_stat};
            `CGACS_OFS_IRQ_EN: rd = {31'h0000_0000, st_reg.irq_en};
            default: rd = 32'h0000_0000;
        endcase
        st_next.rdata = req ? rd : 32'h0000_0000;
        if (wr) begin
            case (wb_adr_i)
                `CGACS_OFS_CONV_CTL: begin
                    st_next.conv_ctl = 8'(cgacs_merge(32'(st_reg.conv_ctl), wb_dat_i,
                                                      wb_sel_i));
                end
                `CGACS_OFS_CLK_CTL: begin
                    st_next.clk_ctl = 4'(cgacs_merge(32'(st_reg.clk_ctl), wb_dat_i,
                                                     wb_sel_i));
                end
                `CGACS_OFS_MULT: begin
                    st_next.mult = MULT_W'(cgacs_merge(32'(st_reg.mult), wb_dat_i,
                                                       wb_sel_i));
                end
                `CGACS_OFS_IRQ_EN: begin
                    if (wb_sel_i[0]) begin
                        st_next.irq_en = wb_dat_i[0];
                    end
                end
                `CGACS_OFS_IRQ_CLR: begin
                    if (wb_sel_i[0] && wb_dat_i[0]) begin
                        st_next.irq_stat = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end

        st_next.osc_en = oscillator_enable_request | run_in_stop;
        st_next.xtal_clk = xtal_level;
        st_next.ref_clk = st_reg.xtal_clk;

        // Source hand-over only while base is low, on the new source's edge
        src_edge = st_reg.base_active ? vco_rise : xtal_rise;
        if (!st_reg.base_clk && (base_sel_req != st_reg.base_active)) begin
            src_edge = base_sel_req ? vco_rise : xtal_rise;
            if (src_edge) begin
                st_next.base_active = base_sel_req;
            end
        end
        if (src_edge) begin
            st_next.base_clk = ~st_reg.base_clk;
        end
        st_next.bus_rise = 1'b0;
        if (src_edge && !st_reg.base_clk) begin
            st_next.bus_clk = ~st_reg.bus_clk;
            st_next.bus_rise = ~st_reg.bus_clk;
        end

        // Tri-state style detector: both sides seen resets both pulses
        if (xtal_rise) begin
            st_next.pump_up = 1'b1;
        end
        if (fb_tick) begin
            st_next.pump_dn = 1'b1;
        end
        if (st_next.pump_up && st_next.pump_dn) begin
            st_next.pump_up = 1'b0;
            st_next.pump_dn = 1'b0;
        end

        // Feedback ticks counted over a window of reference edges
        if (fb_tick && st_reg.fb_cnt != 8'hFF) begin
            st_next.fb_cnt = 8'(st_reg.fb_cnt + 8'h01);
        end
        lock_new = st_reg.lock;
        if (xtal_rise) begin
            if (st_reg.win_cnt == 8'(`CGACS_LOCK_WINDOW - 8'h01)) begin
                diff = cgacs_absdiff(st_reg.fb_cnt, `CGACS_LOCK_WINDOW);
                st_next.win_cnt = 8'h00;
                st_next.fb_cnt = fb_tick ? 8'h01 : 8'h00;
                if (auto_bw) begin
                    st_next.acquisition_indicator = (diff <= `CGACS_TRACK_TOL);
                    lock_new = (diff <= `CGACS_LOCK_TOL);
                end
            end else begin
                st_next.win_cnt = 8'(st_reg.win_cnt + 8'h01);
            end
        end
        if (!auto_bw) begin
            st_next.acquisition_indicator = acq_manual;
            lock_new = 1'b0;
        end
        lock_evt = auto_bw && (lock_new != st_reg.lock);
        st_next.lock = lock_new;
        // A toggle in the clearing cycle still sets the flag
        if (lock_evt) begin
            st_next.irq_stat = 1'b1;
        end
        st_next.irq = st_next.irq_stat & st_next.irq_en & auto_bw;

        st_next.res_valid = conv_result_valid;
        if (conv_result_valid) begin
            fmt = cgacs_justify(just_sel, conv_result_raw);
            st_next.res_high = fmt[15:8];
            st_next.res_low = fmt[7:0];
        end
    end

    always_ff @(posedge clk or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            st_reg <= '0;
            st_reg.conv_ctl <= `CGACS_CONV_CTL_RST;
            st_reg.clk_ctl <= `CGACS_CLK_CTL_RST;
            st_reg.mult <= MULT_W'(`CGACS_MULT_RST);
        end else begin
            st_reg <= st_next;
        end
    end

    assign wb_dat_o = st_reg.rdata;
    assign wb_ack_o = st_reg.ack;
    assign irq_o = st_reg.irq;
    assign oscillator_enable = st_reg.osc_en;
    assign crystal_clock = st_reg.xtal_clk;
    assign pll_reference_clock = st_reg.ref_clk;
    assign base_clock = st_reg.base_clk;
    assign base_source_vco = st_reg.base_active;
    assign bus_clock = st_reg.bus_clk;
    assign vco_feedback_clock = fb_tick;
    assign final_reference_clock = xtal_rise;
    assign pump_up = st_reg.pump_up;
    assign pump_down = st_reg.pump_dn;
    assign tracking_mode = st_reg.acquisition_indicator;
    assign pll_locked = st_reg.lock;
    assign converter_clock_tick = conv_tick;
    assign result_high = st_reg.res_high;
    assign result_low = st_reg.res_low;
    assign result_valid = st_reg.res_valid;

endmodule // cgacs_top

// ==== shared/cgacs_consts.svh ====
/*
 Constants of the clock generator and converter clock select block: register
 offsets, field positions, reset values and detector counts.
 Assumes inclusion by bare name from the package and the design files.
*/
`ifndef CGACS_CONSTS_SVH
`define CGACS_CONSTS_SVH

`define CGACS_OFS_CONV_CTL 8'h00
`define CGACS_OFS_CLK_CTL 8'h04
`define CGACS_OFS_MULT 8'h08
`define CGACS_OFS_STATUS 8'h0C
`define CGACS_OFS_IRQ_STAT 8'h10
`define CGACS_OFS_IRQ_CLR 8'h14
`define CGACS_OFS_IRQ_EN 8'h18

`define CGACS_CONV_PRESC_POS 5
`define CGACS_CONV_SRC_POS 4
`define CGACS_CONV_JUST_POS 2
`define CGACS_CONV_CTL_RST 8'h04

`define CGACS_CTL_BASE_SEL_POS 0
`define CGACS_CTL_AUTO_POS 1
`define CGACS_CTL_ACQ_POS 2
`define CGACS_CTL_RIS_POS 3
`define CGACS_CLK_CTL_RST 4'h2

`define CGACS_MULT_W 12
`define CGACS_MULT_RST 12'h001

`define CGACS_JUST_TRUNC 2'h0
`define CGACS_JUST_RIGHT 2'h1
`define CGACS_JUST_LEFT 2'h2
`define CGACS_JUST_SIGNED 2'h3

`define CGACS_LOCK_WINDOW 8'h20
`define CGACS_LOCK_TOL 8'h01
`define CGACS_TRACK_TOL 8'h04

`endif

// ==== shared/cgacs_pkg.sv ====
/*
 Types of the clock generator and converter clock select block.
 Assumes cgacs_consts.svh is on the include path.
*/
`include "cgacs_consts.svh"

package cgacs_pkg;

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic rise;
    } cgacs_sync_state_t;

    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
        logic [7:0] conv_ctl;
        logic [3:0] clk_ctl;
        logic [`CGACS_MULT_W-1:0] mult;
        logic irq_stat;
        logic irq_en;
        logic irq;
        logic base_active;
        logic base_clk;
        logic bus_clk;
        logic bus_rise;
        logic xtal_clk;
        logic ref_clk;
        logic osc_en;
        logic pump_up;
        logic pump_dn;
        logic [7:0] win_cnt;
        logic [7:0] fb_cnt;
        logic lock;
        logic acquisition_indicator;
        logic [7:0] res_high;
        logic [7:0] res_low;
        logic res_valid;
    } cgacs_state_t;

endpackage

// ==== verif/cgacs_checker.sv ====
/*
 Concurrent checks on the ports of cgacs_top, attached by bind below.
 Assumes pin clocks run well below a third of clk.
*/
module cgacs_checker
    import cgacs_pkg::*;
#(
    parameter int MULT_W = 12
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wb_ack_o,
    input wire logic oscillator_enable_request,
    input wire logic oscillator_enable,
    input wire logic crystal_clock,
    input wire logic pll_reference_clock,
    input wire logic base_clock,
    input wire logic base_source_vco,
    input wire logic bus_clock,
    input wire logic vco_feedback_clock,
    input wire logic final_reference_clock,
    input wire logic pump_up,
    input wire logic pump_down,
    input wire logic converter_clock_tick,
    input wire logic conv_result_valid,
    input wire logic result_valid,
    input wire logic [7:0] result_high,
    input wire logic [7:0] result_low
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("bus ack held past one cycle");
    osc_enable_a: assert property (oscillator_enable_request |=> oscillator_enable)
        else $error("oscillator not enabled on request");
    ref_follow_a: assert property ($rose(crystal_clock) |=> $rose(pll_reference_clock))
        else $error("reference clock does not follow crystal clock");
    base_high_a: assert property ($rose(base_clock) |=> base_clock [*2])
        else $error("truncated base clock high phase");
    base_switch_a: assert property ($changed(base_source_vco) |-> !$past(base_clock))
        else $error("base source changed while base clock high");
    bus_toggle_a: assert property ($changed(bus_clock) |-> base_clock)
        else $error("bus clock moved outside a base clock high phase");
    tick_pulse_a: assert property (converter_clock_tick |=> !converter_clock_tick)
        else $error("converter tick wider than one cycle");
    fb_pulse_a: assert property (vco_feedback_clock |=> !vco_feedback_clock)
        else $error("feedback pulse wider than one cycle");
    pump_set_a: assert property (final_reference_clock && !vco_feedback_clock && !pump_down
        |-> ##[0:1] pump_up)
        else $error("reference pulse did not raise pump up");
    result_taken_a: assert property (conv_result_valid |=> result_valid)
        else $error("result not presented one cycle after valid");
    result_hold_a: assert property (!result_valid |-> $stable({result_high, result_low}))
        else $error("result bytes changed without a new result");
endmodule // cgacs_checker

bind cgacs_top cgacs_checker #(.MULT_W(MULT_W)) u_cgacs_checker (
    .clk, .rst_n, .wb_ack_o, .oscillator_enable_request, .oscillator_enable,
    .crystal_clock, .pll_reference_clock, .base_clock, .base_source_vco, .bus_clock,
    .vco_feedback_clock, .final_reference_clock, .pump_up, .pump_down,
    .converter_clock_tick, .conv_result_valid, .result_valid, .result_high, .result_low
);

// ==== verif/cgacs_partner.sv ====
/*
 Far side model: crystal and VCO pin sources and the converter feeding raw results.
 Assumes send_result is called just after a rising edge of clk.
*/
module cgacs_partner #(
    parameter int XTAL_HALF = 10,
    parameter int VCO_HALF = 5
) (
    input wire logic clk,
    output logic crystal_pin,
    output logic vco_pin,
    output logic [9:0] conv_result_raw,
    output logic conv_result_valid
);
    timeunit 1ns;
    timeprecision 1ps;
    int xc = 0;
    int vc = 0;

    initial begin
        crystal_pin = 1'b0;
        vco_pin = 1'b0;
        conv_result_raw = 10'h000;
        conv_result_valid = 1'b0;
    end

    // Oscillators run free; they never stop between conversions
    always @(posedge clk) begin
        xc <= (xc == XTAL_HALF - 1) ? 0 : xc + 1;
        vc <= (vc == VCO_HALF - 1) ? 0 : vc + 1;
        if (xc == XTAL_HALF - 1) begin
            crystal_pin <= ~crystal_pin;
        end
        if (vc == VCO_HALF - 1) begin
            vco_pin <= ~vco_pin;
        end
    end

    task automatic send_result(input logic [9:0] raw);
        conv_result_raw <= raw;
        conv_result_valid <= 1'b1;
        @(posedge clk);
        conv_result_valid <= 1'b0;
        // Released data shows the inverse, so a late sample cannot pass
        conv_result_raw <= ~raw;
    endtask
endmodule // cgacs_partner

// ==== verif/cgacs_test.sv ====
/*
 Self-checking bench for cgacs_top: registers over Wishbone, clock ratios,
 result formats and the lock interrupt. Assumes cgacs_partner drives the pins.
*/
`include "cgacs_consts.svh"

module cgacs_test import cgacs_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] CONV = `CGACS_OFS_CONV_CTL;
    localparam logic [7:0] CTL = `CGACS_OFS_CLK_CTL;
    localparam logic [7:0] MUL = `CGACS_OFS_MULT;
    localparam logic [7:0] STA = `CGACS_OFS_STATUS;
    localparam logic [7:0] IST = `CGACS_OFS_IRQ_STAT;
    localparam logic [7:0] ICL = `CGACS_OFS_IRQ_CLR;
    localparam logic [7:0] IEN = `CGACS_OFS_IRQ_EN;
    int bad_count = 0;
    int total_checks = 0;
    int cycles = 0;
    int cnt [7];
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic osc_req = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat = 32'h0;
    logic [31:0] q, wb_dat_o;
    logic [9:0] conv_result_raw;
    logic [7:0] result_high, result_low;
    logic [6:0] cur, prv;
    logic [2:0] lv;
    logic wb_ack_o, irq_o, crystal_pin, vco_pin, conv_result_valid, oscillator_enable;
    logic crystal_clock, base_clock, base_source_vco, bus_clock, vco_feedback_clock;
    logic tracking_mode, pll_locked, converter_clock_tick;
    logic [9:0] raws [2] = '{10'h2B5, 10'h14A};
    logic [2:0] pre [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7};

    cgacs_top u_cgacs_top (
        .clk, .rst_n, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o, .wb_ack_o, .irq_o, .crystal_pin,
        .vco_pin, .oscillator_enable_request(osc_req), .conv_result_raw,
        .conv_result_valid, .oscillator_enable, .crystal_clock, .pll_reference_clock(),
        .base_clock, .base_source_vco, .bus_clock, .vco_feedback_clock,
        .final_reference_clock(), .pump_up(), .pump_down(), .tracking_mode, .pll_locked,
        .converter_clock_tick, .result_high, .result_low, .result_valid()
    );
    cgacs_partner u_cgacs_partner (
        .clk, .crystal_pin, .vco_pin, .conv_result_raw, .conv_result_valid
    );

    assign cur = {crystal_clock, vco_pin, vco_feedback_clock, converter_clock_tick,
                  bus_clock, base_clock, crystal_pin};
    assign lv = {pll_locked, base_source_vco, irq_o};

    always #4 clk = ~clk;

    always @(posedge clk) begin
        for (int i = 0; i < 7; i++) begin
            if (cur[i] && !prv[i]) begin
                cnt[i]++;
            end
        end
        prv <= cur;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            bad_count++;
            $display("mismatch at %0t: run timed out", $time);
            tally_and_finish();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Edge counts over a window drift by one with phase
    task automatic near(input int got, input int exp);
        total_checks++;
        if (got < exp - 1 || got > exp + 1) begin
            bad_count++;
            $display("mismatch at %0t: count %0d expected %0d", $time, got, exp);
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        do begin
            @(posedge clk);
            n++;
        end while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        check(32'(n), 32'h2);
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        check(q, e);
    endtask

    task automatic measure();
        cnt = '{default: 0};
        repeat (1280) @(posedge clk);
    endtask

    task automatic wait_for(input int i, input logic v, input int lim);
        int n;
        n = 0;
        while (lv[i] !== v && n < lim) begin
            @(posedge clk);
            n++;
        end
        check(lv[i], v);
    endtask

    function automatic logic [31:0] fmt(input logic [9:0] r, input int m);
        case (m)
            0: return {24'h0, r[9:2]};
            1: return {22'h0, r};
            2: return {16'h0, r, 6'h00};
            default: return {16'h0, ~r[9], r[8:0], 6'h00};
        endcase
    endfunction

    task automatic tally_and_finish();
        if (bad_count == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        rd(CONV, 32'h04);
        rd(CTL, 32'h2);
        rd(MUL, 32'h1);
        rd(8'h40, 32'h0);
        wr(STA, 32'hF);
        rd(STA, 32'h0);
        foreach (raws[j]) begin
            for (int m = 0; m < 4; m++) begin
                wr(CONV, 32'(m) << 2);
                u_cgacs_partner.send_result(raws[j]);
                repeat (2) @(posedge clk);
                check({result_high, result_low}, fmt(raws[j], m));
            end
        end
        for (int s = 0; s < 2; s++) begin
            foreach (pre[k]) begin
                wr(CONV, 32'({pre[k], s[0], 4'h4}));
                measure();
                near(cnt[3], cnt[0] / (s ? 4 : 1) / (pre[k][2] ? 16 : 1 << pre[k][1:0]));
                near(cnt[1], cnt[0] / 2);
                near(cnt[2], cnt[0] / 4);
                near(cnt[6], cnt[0]);
            end
        end
        // Crystal over eight lands near the converter's preferred rate
        wr(CONV, 32'h64);
        osc_req <= 1'b1;
        repeat (3) @(posedge clk);
        check(oscillator_enable, 1'b1);
        osc_req <= 1'b0;
        repeat (3) @(posedge clk);
        check(oscillator_enable, 1'b0);
        wr(CTL, 32'hA);
        rd(STA, 32'h8);
        wr(CTL, 32'hB);
        wait_for(1, 1'b1, 200);
        measure();
        near(cnt[1], cnt[5] / 2);
        near(cnt[2], cnt[5] / 4);
        near(cnt[4], cnt[5]);
        wr(MUL, 32'h3);
        measure();
        near(cnt[4], cnt[5] / 3);
        wr(IEN, 32'h1);
        wr(MUL, 32'h2);
        wait_for(2, 1'b1, 3000);
        wait_for(0, 1'b1, 4);
        rd(STA, 32'hF);
        rd(IST, 32'h1);
        wr(IEN, 32'h0);
        wait_for(0, 1'b0, 4);
        wr(IEN, 32'h1);
        wait_for(0, 1'b1, 4);
        wr(ICL, 32'h1);
        wait_for(0, 1'b0, 4);
        rd(IST, 32'h0);
        wr(MUL, 32'h3);
        wait_for(2, 1'b0, 3000);
        wait_for(0, 1'b1, 4);
        measure();
        check(tracking_mode, 1'b0);
        wr(ICL, 32'h1);
        wr(MUL, 32'h2);
        wait_for(2, 1'b1, 3000);
        wr(ICL, 32'h1);
        wr(CTL, 32'hD);
        measure();
        check(pll_locked, 1'b0);
        check(irq_o, 1'b0);
        rd(IST, 32'h0);
        tally_and_finish();
    end
endmodule // cgacs_test
